// >>> verif/muh_host_model.sv
// host processor model driving the byte-wide port of the math unit
`timescale 1ns/100ps
`default_nettype none
module muh_host_model
  import muh_pkg::*;
(
  input wire logic mclk,    // device clock
  input wire logic dataOe,  // device is driving the data bus
  output var muh_hbus_t pins // host side of the port pins
);
  // strobes idle high; a released data byte is shown inverted
  initial pins = BUS_IDLE;

  // read: hold select, location and strobe until the device drives
  task automatic hostRead(input logic sel, input logic loc,
    output logic ok);
    ok = 1'b0;
    @(posedge mclk);
    pins.csN <= ~sel;
    pins.loc <= loc;
    pins.rdN <= 1'b0;
    for (int i = 0; i < 12 && !ok; i++)
    begin
      @(posedge mclk);
      ok = dataOe;
    end
    pins.rdN <= 1'b1;
    pins.csN <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : hostRead

  // write: select drops after the strobe so the byte is never aborted
  task automatic hostWrite(input logic sel, input logic loc,
    input logic [7:0] d);
    @(posedge mclk);
    pins.csN <= ~sel;
    pins.loc <= loc;
    pins.data <= d;
    pins.wrN <= 1'b0;
    repeat (4) @(posedge mclk);
    pins.wrN <= 1'b1;
    @(posedge mclk);
    pins.csN <= 1'b1;
    pins.data <= ~d;
    repeat (5) @(posedge mclk);
  endtask : hostWrite
endmodule : muh_host_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking testbench of the math unit completion handshake
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import muh_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic doneAckN = 1'b1, svcAckN = 1'b1, busy = 1'b0, readOk;
  logic [2:0] flags = 3'h0;
  logic [7:0] dataByte = 8'h00, dataOut, writeData, wd;
  logic dataOe, commandDone, serviceRequest, errorOut;
  logic readPop, writeStrobe, writeLoc, oePrev = 1'b0;
  logic [8:0] e;
  muh_cmpl_t cmpl = '0;
  muh_hbus_t hostPins, hostIn;
  int numErrors = 0, totalChecks = 0, cnt;
  int pops = 0, popsExp = 0;
  logic [8:0] rdQ[$], wrQ[$];

  always #12.5 mclk = ~mclk;

  // data wire: device wins while it drives, else the host byte
  assign hostIn = {hostPins[11:8], dataOe ? dataOut : hostPins.data};

  muh_host_model muh_host_model_i (.mclk(mclk), .dataOe(dataOe),
    .pins(hostPins));

  muh_handshake muh_handshake_i (.mclk(mclk), .reset(reset),
    .hostIn(hostIn), .done_acknowledge_n(doneAckN),
    .service_acknowledge_n(svcAckN), .cmpl(cmpl), .busy(busy),
    .flags(flags), .dataByte(dataByte), .dataOut(dataOut),
    .dataOe(dataOe), .commandDone(commandDone),
    .service_request(serviceRequest), .errorOut(errorOut),
    .readPop(readPop), .writeStrobe(writeStrobe), .writeLoc(writeLoc),
    .writeData(writeData));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // results meet the oldest note; an unnoted result is forced to fail
  always @(posedge mclk)
  begin
    #1;
    if (dataOe && !oePrev)
    begin
      e = rdQ.size() ? rdQ.pop_front() : {1'b1, ~dataOut};
      if (e[8]) check(dataOut, e[7:0]);
    end
    if (writeStrobe)
    begin
      e = wrQ.size() ? wrQ.pop_front() : {~writeLoc, 8'h00};
      check({7'h0, writeLoc}, {7'h0, e[8]});
      check(writeData, e[7:0]);
    end
    // one pop pulse is owed for every selected data read
    if (readPop === 1'b1)
      pops++;
    oePrev = dataOe;
  end

  task automatic complete(input logic sreqEn, input muh_err_t err);
    @(posedge mclk);
    cmpl <= {1'b1, sreqEn, err};
    @(posedge mclk);
    cmpl <= '0;
    @(posedge mclk);
    #1;
  endtask : complete

  // random busy: status is polled while a command may be running
  task automatic rd(input logic sel, input logic loc, input logic cmp);
    @(posedge mclk);
    dataByte <= 8'($urandom);
    flags <= 3'($urandom);
    busy <= 1'($urandom);
    @(posedge mclk);
    #1;
    if (sel) rdQ.push_back({cmp, loc ? {busy, flags, 4'h0} : dataByte});
    if (sel && loc == LOC_DATA) popsExp++;
    muh_host_model_i.hostRead(sel, loc, readOk);
    check({7'h0, readOk}, {7'h0, sel});
  endtask : rd

  task automatic wr(input logic sel, input logic loc);
    wd = 8'($urandom);
    if (sel) wrQ.push_back({loc, wd});
    muh_host_model_i.hostWrite(sel, loc, wd);
  endtask : wr

  initial
  begin
    cnt = $urandom(32'h0757);
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    check({5'h0, commandDone, serviceRequest, errorOut}, 8'h00);
    complete(1'b1, 3'h0);
    check({6'h0, commandDone, serviceRequest}, 8'h03);
    // unselected strobes must leave the flags alone
    rd(1'b0, LOC_DATA, 1'b1);
    wr(1'b0, LOC_STATUS);
    check({7'h0, commandDone}, 8'h01);
    rd(1'b1, LOC_DATA, 1'b1);
    check({7'h0, commandDone}, 8'h00);
    // each error kind: a data read keeps it, a status read clears it
    for (int i = 0; i < 3; i++)
    begin
      complete(1'b0, 3'b100 >> i);
      check({6'h0, serviceRequest, errorOut}, 8'h01);
      rd(1'b1, LOC_DATA, 1'b1);
      check({6'h0, commandDone, errorOut}, 8'h01);
      rd(1'b1, LOC_STATUS, 1'b0);
      check({7'h0, errorOut}, 8'h00);
    end
    rd(1'b1, LOC_STATUS, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      complete(1'b1, 3'h0);
      wr(1'b1, 1'(i));
      check({7'h0, commandDone}, 8'h00);
    end
    @(posedge mclk);
    svcAckN <= 1'b0;
    repeat (5) @(posedge mclk);
    svcAckN <= 1'b1;
    #1;
    check({7'h0, serviceRequest}, 8'h00);
    complete(1'b0, 3'h0);
    @(posedge mclk);
    doneAckN <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    check({7'h0, commandDone}, 8'h00);
    // acknowledge held low: completion shows as a single-cycle pulse
    @(posedge mclk);
    cmpl <= {1'b1, 1'b0, 3'h0};
    cnt = 0;
    repeat (6)
    begin
      @(posedge mclk);
      cmpl <= '0;
      #1;
      cnt += commandDone;
    end
    check(8'(cnt), 8'h01);
    @(posedge mclk);
    doneAckN <= 1'b1;
    repeat (4) @(posedge mclk);
    // completion lands in the very cycle a read starts: the clear wins
    fork
      rd(1'b1, LOC_DATA, 1'b1);
      begin
        repeat (5) @(posedge mclk);
        cmpl <= {1'b1, 1'b0, 3'h0};
        @(posedge mclk);
        cmpl <= '0;
      end
    join
    check({7'h0, commandDone}, 8'h00);
    check(8'(pops), 8'(popsExp));
    check(8'(rdQ.size() + wrQ.size()), 8'h00);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> verilog/muh_handshake.sv
// host port strobing and completion flags of the math unit
`timescale 1ns/100ps
`default_nettype none
module muh_handshake
  import muh_pkg::*;
(
  input wire logic mclk,                   // device clock, 40 MHz
  input wire logic reset,                  // async reset, high
  input wire muh_hbus_t hostIn,            // host pins, active low strobes
  input wire logic done_acknowledge_n,     // done acknowledge, low
  input wire logic service_acknowledge_n,  // service acknowledge, low
  input wire muh_cmpl_t cmpl,              // datapath completion report
  input wire logic busy,                   // datapath executing
  input wire logic [2:0] flags,            // datapath result flags
  input wire logic [7:0] dataByte,         // byte at the data location
  output logic [7:0] dataOut,              // data bus output value
  output logic dataOe,                     // data bus output enable
  output logic commandDone,                // end of execution flag
  output logic service_request,            // service request flag
  output logic errorOut,                   // error flag
  output logic readPop,                    // pulse: data byte taken
  output logic writeStrobe,                // pulse: byte stored
  output logic writeLoc,                   // location of stored byte
  output logic [7:0] writeData             // stored byte
);

  muh_hbus_t hostSync;
  logic [1:0] ackSync;
  logic csAct;
  logic rdAct;
  logic wrAct;
  logic doneAckLow;
  logic svcAckLow;
  logic rdFall;
  logic wrRise;
  logic accessClear;
  logic statusRead;
  logic [7:0] statusByte;
  logic [7:0] selByte;
  logic [7:0] wrHold_reg;
  logic wrLocHold_reg;
  logic done_reg;
  logic done_next;
  logic sreq_reg;
  logic sreq_next;
  logic [2:0] err_reg;
  logic [2:0] err_next;
  logic [2:0] errSet;
  muh_acc_t acc_reg;
  muh_acc_t acc_next;

  // pins and acknowledges cross into mclk before any decode
  muh_sync #(
    .WIDTH(14),
    .RST_VAL({BUS_IDLE, 2'b11})
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({hostIn, done_acknowledge_n, service_acknowledge_n}),
    .dout({hostSync, ackSync})
  );

  // active-high views of the synchronised pins
  assign csAct = ~hostSync.csN;
  assign rdAct = csAct & ~hostSync.rdN;
  assign wrAct = csAct & ~hostSync.wrN;
  assign doneAckLow = ~ackSync[1];
  assign svcAckLow = ~ackSync[0];

  // access sequencer: one read or one write at a time
  always_comb
  begin
    acc_next = acc_reg;
    case (acc_reg)
      ACC_IDLE:
      begin
        if (rdAct)
          acc_next = ACC_READ;
        else if (wrAct)
          acc_next = ACC_WRITE;
      end
      ACC_READ:
      begin
        if (!rdAct)
          acc_next = ACC_IDLE;
      end
      ACC_WRITE:
      begin
        if (!wrAct)
          acc_next = ACC_IDLE;
      end
      default:
        acc_next = ACC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      acc_reg <= ACC_IDLE;
    else
      acc_reg <= acc_next;
  end

  // strobe edges; a write ends on rising write strobe with select held
  assign rdFall = (acc_reg == ACC_IDLE) & rdAct;
  assign wrRise = (acc_reg == ACC_WRITE) & csAct & hostSync.wrN;
  assign accessClear = rdFall | wrRise;
  assign statusRead = rdFall & (hostSync.loc == LOC_STATUS);

  // status byte; reads are served even while busy
  always_comb
  begin
    statusByte = BYTE_RST;
    statusByte[STS_BUSY_BIT] = busy;
    statusByte[STS_FLAG_MSB:STS_FLAG_LSB] = flags;
    statusByte[STS_ERR_MSB:STS_ERR_LSB] = err_reg;
    statusByte[STS_SPARE_BIT] = 1'b0;
  end

  // location select chooses what is returned
  assign selByte = (hostSync.loc == LOC_STATUS) ? statusByte
    : dataByte;

  // read data comes from a flop and follows location while read is low
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      dataOut <= BYTE_RST;
      dataOe <= 1'b0;
    end
    else
    begin
      dataOe <= rdAct;
      if (rdAct)
        dataOut <= selByte;
    end
  end

  // data pop pulse, once per read of the data location
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      readPop <= 1'b0;
    else
      readPop <= rdFall & (hostSync.loc == LOC_DATA);
  end

  // byte and location track the bus while write is low
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wrHold_reg <= BYTE_RST;
      wrLocHold_reg <= LOC_DATA;
    end
    else if (wrAct)
    begin
      wrHold_reg <= hostSync.data;
      wrLocHold_reg <= hostSync.loc;
    end
  end

  // the held byte is committed at the end of the write
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      writeStrobe <= 1'b0;
      writeLoc <= LOC_DATA;
      writeData <= BYTE_RST;
    end
    else
    begin
      writeStrobe <= wrRise;
      if (wrRise)
      begin
        writeLoc <= wrLocHold_reg;
        writeData <= wrHold_reg;
      end
    end
  end

  // done flop: bus access beats completion, completion beats acknowledge
  // so a tied-low acknowledge still lets one clock of done out
  always_comb
  begin
    done_next = done_reg;
    if (accessClear)
      done_next = 1'b0;
    else if (cmpl.done)
      done_next = 1'b1;
    else if (doneAckLow)
      done_next = 1'b0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      done_reg <= DONE_RST;
    else
      done_reg <= done_next;
  end

  assign commandDone = done_reg;

  // service request; a tied-low acknowledge still yields a short pulse
  always_comb
  begin
    sreq_next = sreq_reg;
    if (cmpl.done)
      sreq_next = cmpl.sreqEnable;
    else if (svcAckLow)
      sreq_next = 1'b0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      sreq_reg <= SREQ_RST;
    else
      sreq_reg <= sreq_next;
  end

  assign service_request = sreq_reg;

  // sticky error bits; a fresh event survives a coincident status read
  assign errSet = {cmpl.err.divZero, cmpl.err.overflow, cmpl.err.underflow};

  always_comb
  begin
    err_next = err_reg;
    if (statusRead)
      err_next = ERR_RST;
    err_next = err_next | errSet;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      err_reg <= ERR_RST;
    else
      err_reg <= err_next;
  end

  assign errorOut = |err_reg;

  // assertion helpers
  logic accessClear_d;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      accessClear_d <= 1'b0;
    else
      accessClear_d <= accessClear;
  end

  // read data drives the bus only for an active select and read
  read_drive_a: assert property (@(posedge mclk) disable iff (reset)
    rdAct |=> dataOe && (dataOut == $past(selByte)))
    else $error("read data not driven");

  no_cs_read_a: assert property (@(posedge mclk) disable iff (reset)
    hostSync.csN |=> !dataOe)
    else $error("bus driven without select");

  loc_select_a: assert property (@(posedge mclk) disable iff (reset)
    (rdAct && hostSync.loc == LOC_DATA)
    |=> dataOut == $past(dataByte))
    else $error("wrong location returned");

  read_clear_a: assert property (@(posedge mclk) disable iff (reset)
    rdFall |=> !commandDone)
    else $error("done not cleared by read");

  status_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (statusRead && errSet == 3'h0) |=> !errorOut)
    else $error("error not cleared by status read");

  write_commit_a: assert property (@(posedge mclk) disable iff (reset)
    wrRise |=> writeStrobe && writeData == $past(wrHold_reg))
    else $error("write byte not committed");

  write_clear_a: assert property (@(posedge mclk) disable iff (reset)
    wrRise |=> !commandDone)
    else $error("done not cleared by write");

  ack_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (doneAckLow && !cmpl.done) |=> !commandDone)
    else $error("done not forced low");

  done_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    (commandDone && doneAckLow && !cmpl.done) |=> !commandDone)
    else $error("done pulse too long");

  done_set_a: assert property (@(posedge mclk) disable iff (reset)
    (cmpl.done && !accessClear) |=> commandDone)
    else $error("done not set at completion");

  svc_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (svcAckLow && !cmpl.done) |=> !service_request)
    else $error("service request not cleared");

  svc_enable_a: assert property (@(posedge mclk) disable iff (reset)
    cmpl.done |=> service_request == $past(cmpl.sreqEnable))
    else $error("service request enable ignored");

  error_set_a: assert property (@(posedge mclk) disable iff (reset)
    (errSet != 3'h0) |=> errorOut [*1])
    else $error("error event lost");

  clear_prio_a: assert property (@(posedge mclk) disable iff (reset)
    (accessClear && cmpl.done) ##1 accessClear_d |-> !commandDone)
    else $error("completion beat access clear");

endmodule : muh_handshake
`default_nettype wire

// >>> verilog/muh_pkg.sv
// package: constants and carrier types of the completion handshake block
package muh_pkg;

  // synchroniser depth for every pin input
  localparam int SYNC_STAGES = 2;

  // internal locations chosen by location_select
  localparam logic LOC_DATA = 1'b0;
  localparam logic LOC_STATUS = 1'b1;

  // status byte layout
  localparam int STS_BUSY_BIT = 7;
  localparam int STS_FLAG_LSB = 4;
  localparam int STS_FLAG_MSB = 6;
  localparam int STS_ERR_LSB = 1;
  localparam int STS_ERR_MSB = 3;
  localparam int STS_SPARE_BIT = 0;

  // reset values
  localparam logic DONE_RST = 1'b0;
  localparam logic SREQ_RST = 1'b0;
  localparam logic [2:0] ERR_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] BUS_IDLE = 12'h0e00;

  // host pins as seen at the package boundary
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic loc;
    logic [7:0] data;
  } muh_hbus_t;

  // error events of one execution step
  typedef struct packed {
    logic divZero;
    logic overflow;
    logic underflow;
  } muh_err_t;

  // completion report from the datapath
  typedef struct packed {
    logic done;
    logic sreqEnable;
    muh_err_t err;
  } muh_cmpl_t;

  // access sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } muh_acc_t;

endpackage : muh_pkg

// >>> verilog/muh_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module muh_sync
  import muh_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic mclk,              // device clock
  input wire logic reset,             // async reset, high
  input wire logic [WIDTH-1:0] din,   // asynchronous inputs
  output logic [WIDTH-1:0] dout       // synchronised copy
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule : muh_sync
`default_nettype wire

// >>> verilog/muh_unused_placeholder_removed.sv
// intentionally minimal: no logic in this file
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
